// ==== logic/host_port_device.sv ====
// Device end of the parallel host port with delayed write side effects
// Functional notes
// - Accept plain and FIFO-direct reads
// - Accept programmed writes and TX FIFO writes
// - TX level updates within 135 ns
// - Write side effects may appear late
// - Host waits after writes before reading
// - Wait applies to read after any write
// - Dummy test reads count 45 ns each
// - Slower host needs fewer dummy reads
// - Waits are 0 to 315 ns
// - Read spans chip select and strobe overlap
`timescale 1ns/1ps
`include "host_port_regs.svh"
module host_port_device (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  host_port_if.device                bus,
  input  wire logic                  rx_valid,
  input  wire logic [`HP_DATA_W-1:0] rx_data,
  output logic                       rx_pop,
  output logic                       tx_valid,
  output logic [`HP_DATA_W-1:0]      tx_data,
  input  wire logic                  tx_pop,
  output logic [`HP_DATA_W-1:0]      scratch
);
  localparam int TX_CNT_W = 5;
  localparam logic [TX_CNT_W-1:0] TX_DELAY = TX_CNT_W'(`HP_TX_LEVEL_CYC - 1);
  logic                           rd_active;
  logic                           wr_active;
  logic                           rd_prev;
  logic                           wr_prev;
  logic                           wr_start;
  logic                           rd_start;
  logic [`HP_DATA_W-1:0]          tx_mem [`HP_TX_DEPTH];
  logic [`HP_LEVEL_W-2:0]         wr_ptr;
  logic [`HP_LEVEL_W-2:0]         rd_ptr;
  logic [`HP_LEVEL_W-1:0]         level;
  logic [`HP_LEVEL_W-1:0]         level_shown;
  logic [TX_CNT_W-1:0]            lag;
  logic                           tx_push;
  logic                           tx_full;

  // Read lives while both selects are low, in any order
  assign rd_active = !bus.chip_select_n && !bus.read_strobe_n;
  assign wr_active = !bus.chip_select_n && !bus.write_strobe_n;
  assign rd_start  = rd_active && !rd_prev;
  assign wr_start  = wr_active && !wr_prev;
  assign tx_full   = level == `HP_LEVEL_W'(`HP_TX_DEPTH);
  // Writes to a full FIFO are dropped, matching silent overrun
  assign tx_push   = wr_start && !tx_full &&
                     (bus.fifo_select || bus.addr == `HP_OFF_TX_DATA);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_active;
      wr_prev <= wr_active;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (tx_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (tx_pop && tx_valid) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      level <= level + (tx_push ? 1'b1 : 1'b0) - ((tx_pop && tx_valid) ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[wr_ptr] <= bus.wdata;
    end
  end

  // Level shown lags the true level, stale reads are possible early
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lag         <= '0;
      level_shown <= '0;
    end else if (level != level_shown) begin
      if (lag == TX_DELAY) begin
        lag         <= '0;
        level_shown <= level;
      end else begin
        lag <= lag + 1'b1;
      end
    end else begin
      lag <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scratch <= '0;
    end else if (wr_start && !bus.fifo_select && bus.addr == `HP_OFF_SCRATCH) begin
      scratch <= bus.wdata;
    end
  end

  // Data latched at cycle start so counters stay coherent during the read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.rdata <= '0;
      rx_pop    <= 1'b0;
    end else begin
      rx_pop <= 1'b0;
      if (rd_start) begin
        if (bus.fifo_select || bus.addr == `HP_OFF_RX_DATA) begin
          bus.rdata <= rx_data;
          rx_pop    <= rx_valid;
        end else if (bus.addr == `HP_OFF_TX_LEVEL) begin
          bus.rdata <= `HP_DATA_W'(level_shown);
        end else if (bus.addr == `HP_OFF_BYTE_TEST) begin
          bus.rdata <= `HP_BYTE_TEST_VALUE;
        end else if (bus.addr == `HP_OFF_SCRATCH) begin
          bus.rdata <= scratch;
        end else begin
          bus.rdata <= '0;
        end
      end
    end
  end

  assign bus.rdata_oe_n = !rd_active;
  assign tx_valid       = level != '0;
  assign tx_data        = tx_mem[rd_ptr];
endmodule

// ==== logic/host_port_regs.svh ====
// Constants for the parallel host port: widths, offsets, test value, FIFO depth, timing
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define HP_CLK_PERIOD_NS      10
`define HP_ADDR_W             8
`define HP_DATA_W             32
`define HP_TX_LEVEL_DELAY_NS  135
`define HP_TX_LEVEL_CYC       (`HP_TX_LEVEL_DELAY_NS / `HP_CLK_PERIOD_NS)
`define HP_MAX_WAIT_NS        315
`define HP_MAX_WAIT_CYC       (`HP_MAX_WAIT_NS / `HP_CLK_PERIOD_NS)
`define HP_DUMMY_CYCLE_NS     45
`define HP_DUMMY_CYCLE_CYC    ((`HP_DUMMY_CYCLE_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_STROBE_CYC         4
`define HP_OFF_RX_DATA        8'h00
`define HP_OFF_TX_DATA        8'h20
`define HP_OFF_TX_LEVEL       8'h80
`define HP_OFF_BYTE_TEST      8'h64
`define HP_OFF_SCRATCH        8'h8C
`define HP_BYTE_TEST_VALUE    32'h87654321
`define HP_TX_DEPTH           16
`define HP_LEVEL_W            5
`endif

// ==== logic/host_port_pkg.sv ====
// Command type used by the host end of the parallel host port and by the bench
package host_port_pkg;
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_FIFO_READ,
    CMD_FIFO_WRITE
  } host_cmd_t;
endpackage

// ==== logic/host_port_if.sv ====
// Interface joining the host and the device over the parallel port
`timescale 1ns/1ps
`include "host_port_regs.svh"
interface host_port_if;
  logic                    chip_select_n;
  logic                    read_strobe_n;
  logic                    write_strobe_n;
  logic                    fifo_select;
  logic [`HP_ADDR_W-1:0]   addr;
  logic [`HP_DATA_W-1:0]   wdata;
  logic [`HP_DATA_W-1:0]   rdata;
  logic                    rdata_oe_n;
  modport device (
    input  chip_select_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  fifo_select,
    input  addr,
    input  wdata,
    output rdata,
    output rdata_oe_n
  );
  modport host (
    output chip_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output fifo_select,
    output addr,
    output wdata,
    input  rdata,
    input  rdata_oe_n
  );
endinterface

// ==== logic/host_port_host.sv ====
// Host end of the parallel host port, enforcing write-to-read waits
`timescale 1ns/1ps
`include "host_port_regs.svh"
module host_port_host (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  host_port_if.host                     bus,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire host_port_pkg::host_cmd_t req_cmd,
  input  wire logic [`HP_ADDR_W-1:0]    req_addr,
  input  wire logic [`HP_DATA_W-1:0]    req_wdata,
  input  wire logic [3:0]               req_wait,
  output logic                          rsp_valid,
  output logic [`HP_DATA_W-1:0]         rsp_rdata
);
  typedef enum logic [1:0] {IDLE, GUARD, STROBE, RECOVER} hstate_t;
  localparam logic [5:0] STROBE_LEN = 6'(`HP_STROBE_CYC);
  hstate_t                      state;
  logic [5:0]                   cnt;
  logic [5:0]                   guard;
  logic                         is_read;
  logic                         after_write;

  // Wait in cycles from dummy-read count, 45 ns each rounded up
  function automatic logic [5:0] wait_cycles(input logic [3:0] n);
    wait_cycles = 6'(n * `HP_DUMMY_CYCLE_CYC);
  endfunction

  assign req_ready = state == IDLE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state              <= IDLE;
      cnt                <= '0;
      guard              <= '0;
      is_read            <= 1'b0;
      after_write        <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= '0;
      bus.chip_select_n  <= 1'b1;
      bus.read_strobe_n  <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.fifo_select    <= 1'b0;
      bus.addr           <= '0;
      bus.wdata          <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
      if (guard != '0) begin
        guard <= guard - 1'b1;
      end
      unique case (state)
        IDLE: begin
          if (req_valid) begin
            is_read         <= req_cmd == host_port_pkg::CMD_READ ||
                               req_cmd == host_port_pkg::CMD_FIFO_READ;
            bus.addr        <= req_addr;
            bus.wdata       <= req_wdata;
            bus.fifo_select <= req_cmd == host_port_pkg::CMD_FIFO_READ ||
                               req_cmd == host_port_pkg::CMD_FIFO_WRITE;
            // Only the first read after a write waits; the full wait counts from the read request
            if ((req_cmd == host_port_pkg::CMD_READ ||
                 req_cmd == host_port_pkg::CMD_FIFO_READ) && after_write) begin
              guard <= wait_cycles(req_wait);
            end else begin
              guard <= '0;
            end
            state <= GUARD;
          end
        end
        GUARD: begin
          if (guard <= 6'd1) begin
            bus.chip_select_n  <= 1'b0;
            bus.read_strobe_n  <= !is_read;
            bus.write_strobe_n <= is_read;
            cnt                <= STROBE_LEN;
            guard              <= '0;
            state              <= STROBE;
          end
        end
        STROBE: begin
          if (cnt == 6'd1) begin
            if (is_read) begin
              rsp_rdata <= bus.rdata;
              rsp_valid <= 1'b1;
            end
            after_write        <= !is_read;
            bus.chip_select_n  <= 1'b1;
            bus.read_strobe_n  <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            cnt                <= 6'd2;
            state              <= RECOVER;
          end
        end
        RECOVER: begin
          if (cnt == 6'd1) begin
            state <= IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ==== tb/host_port_props.sv ====
// Wire-level checks on the parallel host port
`timescale 1ns/1ps
`include "host_port_regs.svh"
module host_port_props (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  chip_select_n,
  input wire logic                  read_strobe_n,
  input wire logic                  write_strobe_n,
  input wire logic                  fifo_select,
  input wire logic [`HP_ADDR_W-1:0] addr,
  input wire logic [`HP_DATA_W-1:0] wdata,
  input wire logic [`HP_DATA_W-1:0] rdata,
  input wire logic                  rdata_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_on = !chip_select_n && !read_strobe_n;
  chk_oe_read_span: assert property (rdata_oe_n == !rd_on)
    else $error("data enable outside read span");
  chk_strobe_low_len: assert property ($fell(chip_select_n) |->
    !chip_select_n [*4] ##1 chip_select_n) else $error("select low length wrong");
  chk_strobe_high_gap: assert property ($rose(chip_select_n) |->
    chip_select_n [*2]) else $error("select high gap too short");
  chk_strobe_pair: assert property (chip_select_n ==
    (read_strobe_n && write_strobe_n)) else $error("select and strobe apart");
  chk_one_strobe_only: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  // Skip the latch edge and the one after it, where the loaded data is first sampled
  chk_rdata_hold: assert property ((rd_on && $past(rd_on, 2)) |-> $stable(rdata))
    else $error("read data moved in cycle");
  chk_addr_hold: assert property ((!chip_select_n && $past(!chip_select_n)) |->
    $stable(addr) && $stable(fifo_select) && $stable(wdata)) else $error("address moved");
  chk_write_no_drive: assert property ($fell(write_strobe_n) |->
    rdata_oe_n [*4]) else $error("data driven in write");
  cover property ($fell(read_strobe_n) && fifo_select);
  cover property ($fell(read_strobe_n) && !fifo_select);
  cover property ($fell(write_strobe_n));
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench joining host and device ends of the port
`timescale 1ns/1ps
`include "host_port_regs.svh"
module testbench;
  logic                     clk;
  logic                     rst_b;
  logic                     rx_valid;
  logic [31:0]              rx_data;
  logic                     tx_pop;
  logic                     req_valid;
  logic                     req_ready;
  host_port_pkg::host_cmd_t req_cmd;
  logic [7:0]               req_addr;
  logic [31:0]              req_wdata;
  logic [3:0]               req_wait;
  logic                     rsp_valid;
  logic [31:0]              rsp_rdata;
  logic                     rx_pop;
  logic                     tx_valid;
  logic [31:0]              tx_data;
  logic [31:0]              scratch;
  logic [31:0]              q;
  int                       lat;
  int                       pops;
  int                       cyc;
  int                       n_fail;
  int                       cmp_count;
  int                       waits [6] = '{0, 1, 2, 3, 4, 7};
  host_port_if bus_if ();
  host_port_device u_host_port_device (.clk(clk), .rst_b(rst_b), .bus(bus_if.device),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_pop(rx_pop), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_pop(tx_pop), .scratch(scratch));
  host_port_host u_host_port_host (.clk(clk), .rst_b(rst_b), .bus(bus_if.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_wait(req_wait), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  host_port_props u_props (.clk(clk), .rst_b(rst_b), .chip_select_n(bus_if.chip_select_n),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .fifo_select(bus_if.fifo_select), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .rdata_oe_n(bus_if.rdata_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_pop === 1'b1) pops++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // Latency counts edges from take to first edge seeing the read strobe low
  task automatic acc(input host_port_pkg::host_cmd_t c, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] w);
    int k;
    @(negedge clk);
    req_valid = 1'b1;
    req_cmd   = c;
    req_addr  = a;
    req_wdata = d;
    req_wait  = w;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    lat = 0;
    for (k = 1; k < 80; k++) begin
      @(posedge clk);
      if (lat == 0 && bus_if.read_strobe_n === 1'b0) lat = k;
      if (rsp_valid === 1'b1) q = rsp_rdata;
      if (req_ready === 1'b1 && k > 6) break;
    end
  endtask
  initial begin
    rst_b = 1'b0;
    {rx_valid, tx_pop, req_valid} = 3'h0;
    rx_data = 32'h1234ABCD;
    {req_cmd, req_addr, req_wdata, req_wait} = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    acc(host_port_pkg::CMD_READ, `HP_OFF_BYTE_TEST, 32'h0, 4'h0);
    chk("test word", q, `HP_BYTE_TEST_VALUE);
    acc(host_port_pkg::CMD_READ, 8'h44, 32'h0, 4'h0);
    chk("unmapped", q, 32'h0);
    foreach (waits[i]) begin
      acc(host_port_pkg::CMD_WRITE, `HP_OFF_SCRATCH, 32'hA5A50000 + i, 4'h0);
      acc(host_port_pkg::CMD_READ, `HP_OFF_SCRATCH, 32'h0, waits[i]);
      // Guard ends one edge early, a zero wait still takes one edge to launch
      chk("wait lat", lat, (waits[i] == 0) ? 2 : 1 + 5 * waits[i]);
      if (waits[i] == 7) chk("scratch rd", q, 32'hA5A50000 + i);
      chk("scratch out", scratch, 32'hA5A50000 + i);
      acc(host_port_pkg::CMD_READ, `HP_OFF_BYTE_TEST, 32'h0, 4'h7);
      chk("no 2nd wait", lat, 2);
    end
    for (int i = 0; i < 3; i++)
      acc(host_port_pkg::CMD_FIFO_WRITE, `HP_OFF_TX_DATA, 32'hC0DE0000 + i, 4'h0);
    acc(host_port_pkg::CMD_READ, `HP_OFF_TX_LEVEL, 32'h0, 4'h3);
    chk("tx level", q, 32'h3);
    chk("tx head", tx_data, 32'hC0DE0000);
    chk("tx valid", tx_valid, 1'b1);
    @(negedge clk);
    tx_pop = 1'b1;
    @(negedge clk);
    tx_pop = 1'b0;
    // Shown level lags the pop; no write came first, so the host adds no guard
    repeat (16) @(negedge clk);
    acc(host_port_pkg::CMD_READ, `HP_OFF_TX_LEVEL, 32'h0, 4'h0);
    chk("tx level pop", q, 32'h2);
    chk("tx head pop", tx_data, 32'hC0DE0001);
    @(negedge clk);
    rx_valid = 1'b1;
    acc(host_port_pkg::CMD_FIFO_READ, 8'hF8, 32'h0, 4'h0);
    chk("rx direct", q, 32'h1234ABCD);
    @(negedge clk);
    rx_data = 32'h55AA33CC;
    acc(host_port_pkg::CMD_READ, `HP_OFF_RX_DATA, 32'h0, 4'h0);
    chk("rx pio", q, 32'h55AA33CC);
    chk("rx pops", pops, 2);
    results();
  end
endmodule
